// file: spd_defines.svh
// Timing and field constants of the serial presence-detect slave.
// Assumes a 10 MHz core clock; every cycle count is derived from these figures.
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

`define SPD_CLK_NS       100
`define SPD_TOUT_MIN_NS  25000000
`define SPD_TOUT_MAX_NS  35000000
`define SPD_INIT_NS      500000
`define SPD_WR_TIME_NS   4000000
`define SPD_FILTER_NS    50
`define SPD_PREAMBLE     4'hA
`define SPD_BYTE_BITS    4'h8
`define SPD_MEM_AW       8

`endif

// file: spd_pkg.sv
// Types shared by the serial presence-detect slave.
// Assumes nothing of its surroundings.
package spd_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RX   = 6'h02,
		ST_ACK  = 6'h04,
		ST_TX   = 6'h08,
		ST_MACK = 6'h10,
		ST_WAIT = 6'h20
	} spd_state_t;

	typedef enum logic [1:0] {
		RX_SADDR = 2'h0,
		RX_WADDR = 2'h1,
		RX_DATA  = 2'h2
	} spd_phase_t;

endpackage

// file: spd_mem.sv
// Byte array behind the serial slave, one write port and a registered read.
// Assumes the caller holds the address steady for a cycle before using read data.
`include "spd_defines.svh"

module spd_mem (
	input  wire logic                     clk,
	input  wire logic                     we,
	input  wire logic [`SPD_MEM_AW-1:0]   addr,
	input  wire logic [7:0]               wdata,
	output logic      [7:0]               rdata_q
);

	logic [7:0] mem [0:(1<<`SPD_MEM_AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata_q <= mem[addr];
	end

endmodule // spd_mem

// file: spd_slave.sv
// Serial presence-detect slave: bus pin handling, addressing, byte transfer and timeouts.
// Assumes scl_clk and scl_i are the same bus wire; the bench resolves the open-drain data line.
`include "spd_defines.svh"

module spd_slave import spd_pkg::*; #(
	parameter int unsigned TOUT_CYC = ((`SPD_TOUT_MIN_NS + `SPD_TOUT_MAX_NS) / 2) / `SPD_CLK_NS,
	parameter int unsigned INIT_CYC = `SPD_INIT_NS / `SPD_CLK_NS,
	parameter int unsigned WR_TIME_CYC = `SPD_WR_TIME_NS / `SPD_CLK_NS
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic scl_clk,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic addr_select_bit0,
	input  wire logic addr_select_bit1,
	input  wire logic addr_select_bit2,
	input  wire logic write_protect,
	output logic      sda_o,
	output logic      sda_oe_n,
	output logic      dev_ready,
	output logic      write_busy
);

	function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] sel);
		addr_hit = (b[7:4] == `SPD_PREAMBLE) && (b[3:1] == sel);
	endfunction

	// ==========================================================================
	// Link domain
	// ==========================================================================
	// The link clock stops between frames, so only a toggle and a held bit cross over.
	logic lk_tog_q;
	logic lk_bit_q;

	always_ff @(posedge scl_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lk_tog_q <= 1'b0;
			lk_bit_q <= 1'b1;
		end else begin
			lk_tog_q <= ~lk_tog_q;
			lk_bit_q <= sda_i;
		end
	end

	// ==========================================================================
	// Pin synchronisers and glitch filter
	// ==========================================================================
	logic [1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q, pin_p_q;
	logic [3:0] strap_s1_q, strap_s2_q;
	logic [2:0] tog_s_q;
	logic       scl_f, sda_f, scl_p, sda_p;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			pin_s3_q <= 2'h3;
			pin_f_q  <= 2'h3;
			pin_p_q  <= 2'h3;
		end else begin
			pin_s1_q <= {scl_i, sda_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_p_q  <= pin_f_q;
			// A level must hold for two consecutive samples, 100 ns apart, so a 50 ns pulse never passes.
			for (int i = 0; i < 2; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_f_q[i] <= pin_s2_q[i];
				end
			end
		end
	end

	// Pads carry pull-downs, so a floating strap or protect pin arrives as zero.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			strap_s1_q <= 4'h0;
			strap_s2_q <= 4'h0;
			tog_s_q    <= 3'h0;
		end else begin
			strap_s1_q <= {write_protect, addr_select_bit2, addr_select_bit1, addr_select_bit0};
			strap_s2_q <= strap_s1_q;
			tog_s_q    <= {tog_s_q[1:0], lk_tog_q};
		end
	end

	assign scl_f = pin_f_q[1];
	assign sda_f = pin_f_q[0];
	assign scl_p = pin_p_q[1];
	assign sda_p = pin_p_q[0];

	logic       wp_s;
	logic [2:0] sel_s;
	logic       scl_rise, scl_fall, start_ev, stop_ev, tog_edge, bit_take;
	logic       rise_pend_q, tog_seen_q;

	assign wp_s     = strap_s2_q[3];
	assign sel_s    = strap_s2_q[2:0];
	assign scl_rise = scl_f & ~scl_p;
	assign scl_fall = ~scl_f & scl_p;
	assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
	assign stop_ev  = scl_f & scl_p & ~sda_p & sda_f;
	assign tog_edge = tog_s_q[2] ^ tog_s_q[1];
	// A bit counts only when a filtered rise and a real link edge agree.
	assign bit_take = (scl_rise | rise_pend_q) & (tog_edge | tog_seen_q) & ~start_ev & ~stop_ev;

	always_ff @(posedge ref_clk) begin
		if (sys_rst || scl_fall || bit_take) begin
			rise_pend_q <= 1'b0;
			tog_seen_q  <= 1'b0;
		end else begin
			if (scl_rise) begin
				rise_pend_q <= 1'b1;
			end
			if (tog_edge) begin
				tog_seen_q <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Power-up, timeout and write-cycle timers
	// ==========================================================================
	logic [12:0] init_cnt_q;
	logic        ready_q;
	logic [19:0] low_cnt_q;
	logic        in_xact_q;
	logic        tout;
	logic [15:0] wr_time_cnt_q;
	logic        busy_q;
	logic        wr_pend_q;
	logic        mem_we;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			init_cnt_q <= 13'h0000;
			ready_q    <= 1'b0;
		end else if (!ready_q) begin
			init_cnt_q <= init_cnt_q + 13'h0001;
			ready_q    <= (init_cnt_q == 13'(INIT_CYC - 1));
		end
	end

	assign tout = in_xact_q & ~scl_f & (low_cnt_q == 20'(TOUT_CYC - 1));

	always_ff @(posedge ref_clk) begin
		if (sys_rst || stop_ev || tout) begin
			in_xact_q <= 1'b0;
		end else if (start_ev && ready_q) begin
			in_xact_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !in_xact_q || scl_f) begin
			low_cnt_q <= 20'h00000;
		end else if (!tout) begin
			low_cnt_q <= low_cnt_q + 20'h00001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_pend_q     <= 1'b0;
			busy_q        <= 1'b0;
			wr_time_cnt_q <= 16'h0000;
		end else if (busy_q) begin
			wr_time_cnt_q <= wr_time_cnt_q + 16'h0001;
			busy_q        <= (wr_time_cnt_q != 16'(WR_TIME_CYC - 1));
		end else if (stop_ev && wr_pend_q) begin
			wr_pend_q     <= 1'b0;
			busy_q        <= 1'b1;
			wr_time_cnt_q <= 16'h0000;
		end else if (mem_we) begin
			wr_pend_q <= 1'b1;
		end
	end

	// ==========================================================================
	// Byte engine
	// ==========================================================================
	spd_state_t state_q;
	spd_phase_t phase_q;
	logic [3:0] cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic [7:0] rd_data;
	logic       rw_q;
	logic       oe_n_q;
	logic       byte_end;

	assign byte_end = (state_q == ST_RX) & scl_fall & (cnt_q == `SPD_BYTE_BITS) & ~tout & ~stop_ev;
	assign mem_we   = byte_end & (phase_q == RX_DATA) & ~wp_s;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			phase_q <= RX_SADDR;
			cnt_q   <= 4'h0;
			shift_q <= 8'h00;
			ptr_q   <= 8'h00;
			rw_q    <= 1'b0;
			oe_n_q  <= 1'b1;
		end else if (tout || stop_ev) begin
			state_q <= ST_IDLE;
			oe_n_q  <= 1'b1;
		end else if (start_ev) begin
			state_q <= ready_q ? ST_RX : ST_IDLE;
			phase_q <= RX_SADDR;
			cnt_q   <= 4'h0;
			oe_n_q  <= 1'b1;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_WAIT: begin
				end
				ST_RX: begin
					if (bit_take) begin
						shift_q <= {shift_q[6:0], lk_bit_q};
						cnt_q   <= cnt_q + 4'h1;
					end else if (byte_end) begin
						cnt_q <= 4'h0;
						if (phase_q == RX_SADDR) begin
							if (addr_hit(shift_q, sel_s) && !busy_q) begin
								oe_n_q  <= 1'b0;
								rw_q    <= shift_q[0];
								state_q <= ST_ACK;
							end else begin
								state_q <= ST_WAIT;
							end
						end else begin
							oe_n_q  <= 1'b0;
							state_q <= ST_ACK;
							ptr_q   <= (phase_q == RX_WADDR) ? shift_q : ptr_q + 8'h01;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (phase_q == RX_SADDR && rw_q) begin
							oe_n_q  <= rd_data[7];
							cnt_q   <= 4'h1;
							state_q <= ST_TX;
						end else begin
							oe_n_q  <= 1'b1;
							state_q <= ST_RX;
							phase_q <= (phase_q == RX_SADDR) ? RX_WADDR : RX_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `SPD_BYTE_BITS) begin
							oe_n_q  <= 1'b1;
							ptr_q   <= ptr_q + 8'h01;
							state_q <= ST_MACK;
						end else begin
							oe_n_q <= rd_data[3'(4'h7 - cnt_q)];
							cnt_q  <= cnt_q + 4'h1;
						end
					end
				end
				ST_MACK: begin
					// A master no-acknowledge ends the read; the slave then waits for STOP.
					if (bit_take) begin
						state_q <= lk_bit_q ? ST_WAIT : ST_MACK;
						cnt_q   <= 4'h0;
					end else if (scl_fall && cnt_q == 4'h0) begin
						oe_n_q  <= rd_data[7];
						cnt_q   <= 4'h1;
						state_q <= ST_TX;
					end
				end
			endcase
		end
	end

	spd_mem u_mem (
		.clk     (ref_clk),
		.we      (mem_we),
		.addr    (ptr_q),
		.wdata   (shift_q),
		.rdata_q (rd_data)
	);

	// ==========================================================================
	// Outputs
	// ==========================================================================
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sda_o      <= 1'b0;
			sda_oe_n   <= 1'b1;
			dev_ready  <= 1'b0;
			write_busy <= 1'b0;
		end else begin
			sda_o      <= 1'b0;
			sda_oe_n   <= oe_n_q;
			dev_ready  <= ready_q;
			write_busy <= busy_q;
		end
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	property p_tout_release;
		@(posedge ref_clk) disable iff (sys_rst) tout |=> (state_q == ST_IDLE) && oe_n_q ##1 sda_oe_n;
	endproperty
	a_tout_release: assert property (p_tout_release) else $error("timeout did not release bus");

	property p_low_restart;
		@(posedge ref_clk) disable iff (sys_rst) scl_f |=> (low_cnt_q == 20'h00000);
	endproperty
	a_low_restart: assert property (p_low_restart) else $error("low counter kept running");

	property p_count_in_xact;
		@(posedge ref_clk) disable iff (sys_rst) (low_cnt_q != 20'h00000) |-> $past(in_xact_q);
	endproperty
	a_count_in_xact: assert property (p_count_in_xact) else $error("counted outside transaction");

	property p_drive_on_fall;
		@(posedge ref_clk) disable iff (sys_rst)
			$fell(oe_n_q) |-> $past(scl_fall) && !$past(start_ev);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall) else $error("data driven off falling edge");

	property p_open_drain;
		@(posedge ref_clk) disable iff (sys_rst) ##1 (sda_o == 1'b0);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");

	property p_wp_block;
		@(posedge ref_clk) disable iff (sys_rst) wp_s |-> !mem_we;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("write while protected");

	property p_filter;
		@(posedge ref_clk) disable iff (sys_rst)
			$changed(scl_f) |-> ($past(pin_s2_q[1]) == scl_f) && ($past(pin_s3_q[1]) == scl_f);
	endproperty
	a_filter: assert property (p_filter) else $error("clock glitch passed filter");

	property p_not_ready;
		@(posedge ref_clk) disable iff (sys_rst) !ready_q |=> (state_q == ST_IDLE) && oe_n_q;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("active before ready");

	property p_addr_match;
		@(posedge ref_clk) disable iff (sys_rst)
			(state_q == ST_RX && phase_q == RX_SADDR) ##1 (state_q == ST_ACK)
			|-> $past(addr_hit(shift_q, sel_s));
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("acknowledged foreign address");

	property p_ack_data;
		@(posedge ref_clk) disable iff (sys_rst)
			byte_end && (phase_q != RX_SADDR) |=> !oe_n_q ##1 !sda_oe_n;
	endproperty
	a_ack_data: assert property (p_ack_data) else $error("data byte not acknowledged");

	property p_busy_nack;
		@(posedge ref_clk) disable iff (sys_rst)
			busy_q && byte_end && (phase_q == RX_SADDR) |=> (state_q == ST_WAIT) && oe_n_q;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("addressed during write cycle");

endmodule // spd_slave

// file: spd_bus_master.sv
// Bus master model that drives the serial clock and data wires of the slave.
// Assumes the bench resolves the open-drain data wire and returns its level on sda_w.
module spd_bus_master #(
	parameter int Q = 10
) (
	input  wire logic ref_clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_m
);
	timeunit 1ns;
	timeprecision 1ns;

	// When set, every low data bit gets a one-cycle high pulse while the clock is high.
	logic glitch;

	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		glitch = 1'b0;
	end

	// ==========================================================
	// Bus conditions
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic start();
		@(posedge ref_clk) sda_m <= 1'b1;
		wait_n(Q);
		scl <= 1'b1;
		wait_n(Q);
		sda_m <= 1'b0;
		wait_n(Q);
		scl <= 1'b0;
	endtask

	task automatic stop();
		@(posedge ref_clk) sda_m <= 1'b0;
		wait_n(Q);
		scl <= 1'b1;
		wait_n(Q);
		sda_m <= 1'b1;
		wait_n(Q);
	endtask

	// ==========================================================
	// Bit and byte transfer
	// Data only moves while the clock is low, so a pulse on data is the sole fake condition.
	task automatic bit_io(input logic b, output logic r);
		@(posedge ref_clk) sda_m <= b;
		wait_n(Q);
		scl <= 1'b1;
		wait_n(Q / 2);
		if (glitch && !b) begin
			sda_m <= 1'b1;
			@(posedge ref_clk) sda_m <= 1'b0;
		end
		wait_n(Q / 2);
		r = sda_w;
		scl <= 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] v, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], r);
		end
		bit_io(1'b1, nak);
	endtask

	task automatic recv_byte(input logic m_nak, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(m_nak, r);
	endtask
endmodule // spd_bus_master

// file: test_spd_eeprom_serial_slave_timing.sv
// Self-checking bench of the serial presence-detect slave against a bus master model.
// Assumes the slave and the master model are compiled first; the data wire has a pull-up.
module test_spd_eeprom_serial_slave_timing;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int INIT_CYC = 40;
	localparam int WR_TIME_CYC = 400;
	localparam int TOUT_CYC = 300;

	logic       ref_clk    = 1'b0;
	logic       sys_rst;
	logic [2:0] sel_q      = 3'h0;
	logic       wp_q       = 1'b0;
	logic       scl;
	logic       sda_m;
	logic       sda_o;
	logic       sda_oe_n;
	logic       dev_ready;
	logic       write_busy;
	wire logic  sda_w;
	int         miscompares = 0;
	int         cmp_count   = 0;
	int         cyc         = 0;

	assign sda_w = (sda_oe_n === 1'b0 || sda_m === 1'b0) ? 1'b0 : 1'b1;

	always #50 ref_clk = ~ref_clk;

	spd_slave #(.TOUT_CYC(TOUT_CYC), .INIT_CYC(INIT_CYC), .WR_TIME_CYC(WR_TIME_CYC)) i_dut (
		.ref_clk          (ref_clk),
		.sys_rst          (sys_rst),
		.scl_clk          (scl),
		.scl_i            (scl),
		.sda_i            (sda_w),
		.addr_select_bit0 (sel_q[0]),
		.addr_select_bit1 (sel_q[1]),
		.addr_select_bit2 (sel_q[2]),
		.write_protect    (wp_q),
		.sda_o            (sda_o),
		.sda_oe_n         (sda_oe_n),
		.dev_ready        (dev_ready),
		.write_busy       (write_busy)
	);

	spd_bus_master #(.Q(10)) i_mst (
		.ref_clk (ref_clk),
		.sda_w   (sda_w),
		.scl     (scl),
		.sda_m   (sda_m)
	);

	// ==========================================================
	// Shared helpers
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// A bounded wait; a stuck busy flag shows up as a miscompare rather than a hang.
	task automatic wait_idle();
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < WR_TIME_CYC + 10) begin
			@(posedge ref_clk);
			n++;
		end
		chk("busy_end", {7'h00, write_busy}, 8'h00);
	endtask

	task automatic probe(input logic [3:0] pre, input logic [2:0] s, output logic n);
		i_mst.start();
		i_mst.send_byte({pre, s, 1'b0}, n);
		i_mst.stop();
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
		logic n0, n1, n2, n3;
		i_mst.start();
		i_mst.send_byte({4'hA, sel_q, 1'b0}, n0);
		i_mst.send_byte(p, n1);
		i_mst.send_byte(d0, n2);
		i_mst.send_byte(d1, n3);
		i_mst.stop();
		chk("wr_acks", {4'h0, n0, n1, n2, n3}, 8'h00);
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
		logic       n0, n1, n2;
		logic [7:0] v0, v1;
		i_mst.start();
		i_mst.send_byte({4'hA, sel_q, 1'b0}, n0);
		i_mst.send_byte(p, n1);
		i_mst.start();
		i_mst.send_byte({4'hA, sel_q, 1'b1}, n2);
		i_mst.recv_byte(1'b0, v0);
		i_mst.recv_byte(1'b1, v1);
		i_mst.stop();
		chk("rd_acks", {5'h00, n0, n1, n2}, 8'h00);
		chk("rd_byte0", v0, e0);
		chk("rd_byte1", v1, e1);
		chk("sda_o", {7'h00, sda_o}, 8'h00);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_ready();
		repeat (INIT_CYC) @(posedge ref_clk);
		#1;
		chk("ready_early", {7'h00, dev_ready}, 8'h00);
		chk("sda_idle", {7'h00, sda_oe_n}, 8'h01);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("ready", {7'h00, dev_ready}, 8'h01);
	endtask

	task automatic t_write();
		logic n;
		wr(8'h10, 8'hA5, 8'h3C);
		#1;
		chk("busy", {7'h00, write_busy}, 8'h01);
		probe(4'hA, sel_q, n);
		chk("busy_nak", {7'h00, n}, 8'h01);
		wait_idle();
		rd(8'h10, 8'hA5, 8'h3C);
	endtask

	task automatic t_wp();
		@(posedge ref_clk) wp_q <= 1'b1;
		wr(8'h10, 8'h00, 8'hFF);
		wait_idle();
		@(posedge ref_clk) wp_q <= 1'b0;
		rd(8'h10, 8'hA5, 8'h3C);
	endtask

	task automatic t_addr();
		logic n;
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk) sel_q <= 3'(i);
			probe(4'hA, 3'(i), n);
			chk("sel_hit", {7'h00, n}, 8'h00);
			wait_idle();
			probe(4'hA, 3'(~i), n);
			chk("sel_miss", {7'h00, n}, 8'h01);
		end
		probe(4'h6, sel_q, n);
		chk("utility_nak", {7'h00, n}, 8'h01);
		wait_idle();
		@(posedge ref_clk) sel_q <= 3'h0;
	endtask

	task automatic t_glitch();
		i_mst.glitch = 1'b1;
		wr(8'h20, 8'h00, 8'h00);
		i_mst.glitch = 1'b0;
		wait_idle();
		rd(8'h20, 8'h00, 8'h00);
	endtask

	// The device drives the low top bit of 3Ch while the clock is parked low.
	task automatic t_timeout();
		logic n0, n1, n2;
		i_mst.start();
		i_mst.send_byte({4'hA, sel_q, 1'b0}, n0);
		i_mst.send_byte(8'h11, n1);
		i_mst.start();
		i_mst.send_byte({4'hA, sel_q, 1'b1}, n2);
		repeat (200) @(posedge ref_clk);
		#1;
		chk("short_low", {4'h0, n0, n1, n2, sda_oe_n}, 8'h00);
		repeat (150) @(posedge ref_clk);
		#1;
		chk("timeout_free", {7'h00, sda_oe_n}, 8'h01);
		i_mst.stop();
		rd(8'h10, 8'hA5, 8'h3C);
	endtask

	// A second reset in mid-run; the START that follows lands before the ready time and must be ignored.
	task automatic t_rst();
		logic n;
		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("rst_out", {4'h0, sda_o, dev_ready, write_busy, sda_oe_n}, 8'h01);
		probe(4'hA, sel_q, n);
		chk("early_nak", {7'h00, n}, 8'h01);
		chk("ready_late", {7'h00, dev_ready}, 8'h01);
		rd(8'h10, 8'hA5, 8'h3C);
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic report_and_stop();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		// Raising reset from unknown at time zero gives the link flops a real edge for their asynchronous clear.
		sys_rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_ready();
		t_write();
		t_wp();
		t_addr();
		t_glitch();
		t_timeout();
		t_rst();
		report_and_stop();
	end
endmodule // test_spd_eeprom_serial_slave_timing
